// *** can_wake_pkg.sv ***
// Overview of operation
// - Four selectable edge-rate settings via control
// - Sleep with wake enabled or disabled
// - Sleep disables drivers and normal receiver
// - Sleep accepted even with supply present
// - Return to communicating mode drives recessive
// - Accept pulses wider 500 ns, below 500 us
// - Gap over 500 us clears counter
// - Three pulses within 1.0 ms window
// - Rejected pulse clears counter, no wake
// - Third accepted pulse asserts internal wake
// - Wake clears only in communicating mode
// - Deep sleep wake: regulator on, release reset
// - Stop mode wake: interrupt pulse, set flag
// - Normal or standby wake: flag only
// - Flag holds until communicating and read
// - Wake on pulse pattern, any content
// - Transmit high recessive, low dominant
// - Receive high recessive, low dominant
package can_wake_pkg;

   localparam int CLK_MHZ        = 25;
   localparam int MIN_PULSE_NS   = 500;
   localparam int MAX_PULSE_US   = 500;
   localparam int MAX_GAP_US     = 500;
   localparam int WINDOW_US      = 1000;
   // Least width rounds up, longest times round down
   localparam int MIN_PULSE_CYC  = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int MAX_PULSE_CYC  = MAX_PULSE_US * CLK_MHZ;
   localparam int MAX_GAP_CYC    = MAX_GAP_US * CLK_MHZ;
   localparam int WINDOW_CYC     = WINDOW_US * CLK_MHZ;
   localparam int PULSES_NEEDED  = 3;
   localparam int SLEW_W         = 2;
   localparam int INT_PULSE_CYC  = 4;

   typedef enum logic [1:0] {
      CHIP_NORMAL  = 2'h0,
      CHIP_STANDBY = 2'h1,
      CHIP_STOP    = 2'h2,
      CHIP_SLEEP   = 2'h3
   } chip_mode_e;

   typedef enum logic [1:0] {
      XCVR_COMM   = 2'h0,
      XCVR_SLEEP  = 2'h1,
      XCVR_WAKE   = 2'h3
   } xcvr_state_e;

endpackage

// *** wake_filter.sv ***
`timescale 1ns/1ps
module wake_filter
   import can_wake_pkg::*;
#(
   parameter int MIN_CYC    = MIN_PULSE_CYC,
   parameter int MAX_CYC    = MAX_PULSE_CYC,
   parameter int GAP_CYC    = MAX_GAP_CYC,
   parameter int WIN_CYC    = WINDOW_CYC
)(
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic enable,
   input  wire logic busDom,
   output logic      wakeHit
);
   localparam int CW = $clog2(WIN_CYC + 2);

   logic [CW-1:0] widthCnt_q;
   logic [CW-1:0] gapCnt_q;
   logic [CW-1:0] winCnt_q;
   logic [1:0]    pulseCnt_q;
   logic          domPrev_q;
   logic          fall;
   logic          okWidth;
   logic          gapOut;
   logic          winOut;

   assign fall    = domPrev_q && !busDom;
   assign okWidth = (widthCnt_q >= CW'(MIN_CYC)) && (widthCnt_q < CW'(MAX_CYC));
   assign gapOut  = (pulseCnt_q != 2'h0) && (gapCnt_q >= CW'(GAP_CYC - 1));
   assign winOut  = (pulseCnt_q != 2'h0) && (winCnt_q >= CW'(WIN_CYC));

   // =========================================
   // Edge and width timing
   // Fine counters
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         domPrev_q  <= 1'b0;
         widthCnt_q <= '0;
      end else begin
         domPrev_q <= busDom && enable;
         if (!(busDom && enable))
            widthCnt_q <= '0;
         else if (widthCnt_q != {CW{1'b1}})
            widthCnt_q <= widthCnt_q + CW'(1);
      end
   end

   // =========================================
   // Gap and window timers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gapCnt_q <= '0;
         winCnt_q <= '0;
      end else begin
         if (fall || busDom || pulseCnt_q == 2'h0)
            gapCnt_q <= '0;
         else if (!gapOut)
            gapCnt_q <= gapCnt_q + CW'(1);
         if (pulseCnt_q == 2'h0 && !fall)
            winCnt_q <= '0;
         else if (!winOut)
            winCnt_q <= winCnt_q + CW'(1);
      end
   end

   // =========================================
   // Pulse counter, pattern only
   // Content blind
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pulseCnt_q <= 2'h0;
         wakeHit    <= 1'b0;
      end else begin
         wakeHit <= 1'b0;
         if (!enable || gapOut || winOut) begin
            pulseCnt_q <= 2'h0;
         end else if (fall) begin
            if (!okWidth)
               pulseCnt_q <= 2'h0;
            else if (pulseCnt_q == 2'(PULSES_NEEDED - 1)) begin
               pulseCnt_q <= 2'h0;
               wakeHit    <= 1'b1;
            end else
               pulseCnt_q <= pulseCnt_q + 2'h1;
         end
      end
   end

   bad_pulse_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fall && !okWidth |=> !wakeHit && pulseCnt_q == 2'h0)
      else $error("rejected pulse kept count");
   third_wake_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      enable && fall && okWidth && pulseCnt_q == 2'h2 && !gapOut && !winOut |=> wakeHit)
      else $error("third pulse missed wake");
   gap_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      gapOut |=> pulseCnt_q == 2'h0 && !wakeHit)
      else $error("gap did not clear count");
   win_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      winOut |=> pulseCnt_q == 2'h0)
      else $error("window did not clear count");
endmodule

// *** can_transceiver_mode_wakeup.sv ***
`timescale 1ns/1ps
module can_transceiver_mode_wakeup
   import can_wake_pkg::*;
#(
   parameter int MIN_CYC = MIN_PULSE_CYC,
   parameter int MAX_CYC = MAX_PULSE_CYC,
   parameter int GAP_CYC = MAX_GAP_CYC,
   parameter int WIN_CYC = WINDOW_CYC
)(
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic              txIn,
   input  wire logic              busDiff,
   input  wire logic              wakeRx,
   input  wire logic              sleepCmd,
   input  wire logic              commCmd,
   input  wire logic              wakeEnable,
   input  wire logic [SLEW_W-1:0] slewSel,
   input  wire chip_mode_e        chipMode,
   input  wire logic              transceiver_supply,
   input  wire logic              canRegRead,
   output logic                   rxOut,
   output logic                   drvDominant,
   output logic                   drvEnable,
   output logic                   rxEnable,
   output logic [SLEW_W-1:0]      slewRate_q,
   output logic                   communicating_mode,
   output logic                   bus_wake_flag,
   output logic                   wakeInternal,
   output logic                   regulatorOn,
   output logic                   hostResetRelease,
   output logic                   intPulse
);
   xcvr_state_e   state_q;
   logic [1:0]    txSync_q;
   logic [1:0]    rxSync_q;
   logic [1:0]    wuSync_q;
   logic          wakeEn_q;
   logic          wakeHit;
   logic          commSeen_q;
   logic [2:0]    intCnt_q;
   logic          deepWake_q;
   logic          deepOff;

   // =========================================
   // Pin synchronisers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         txSync_q <= 2'h3;
         rxSync_q <= 2'h0;
         wuSync_q <= 2'h0;
      end else begin
         txSync_q <= {txSync_q[0], txIn};
         rxSync_q <= {rxSync_q[0], busDiff};
         wuSync_q <= {wuSync_q[0], wakeRx};
      end
   end

   // =========================================
   // Transceiver mode
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= XCVR_SLEEP;
         wakeEn_q <= 1'b0;
      end else begin
         case (state_q)
            XCVR_COMM: begin
               if (sleepCmd) begin
                  state_q  <= XCVR_SLEEP;
                  wakeEn_q <= wakeEnable;
               end
            end
            XCVR_SLEEP: begin
               if (commCmd)
                  state_q <= XCVR_COMM;
               else if (wakeHit)
                  state_q <= XCVR_WAKE;
            end
            XCVR_WAKE: begin
               if (commCmd)
                  state_q <= XCVR_COMM;
            end
            default: state_q <= XCVR_SLEEP;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         slewRate_q <= '0;
      else if (commCmd)
         slewRate_q <= slewSel;
   end

   assign communicating_mode = (state_q == XCVR_COMM);
   assign wakeInternal       = (state_q == XCVR_WAKE);

   // =========================================
   // Pattern wake detector
   // Wake only if enabled
   wake_filter #(
      .MIN_CYC (MIN_CYC),
      .MAX_CYC (MAX_CYC),
      .GAP_CYC (GAP_CYC),
      .WIN_CYC (WIN_CYC)
   ) u_filter (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .enable  (state_q == XCVR_SLEEP && wakeEn_q),
      .busDom  (wuSync_q[1]),
      .wakeHit (wakeHit)
   );

   // =========================================
   // Driver and receiver
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         drvDominant <= 1'b0;
         drvEnable   <= 1'b0;
         rxEnable    <= 1'b0;
         rxOut       <= 1'b1;
      end else begin
         drvEnable <= communicating_mode;
         rxEnable  <= communicating_mode;
         drvDominant <= communicating_mode && drvEnable && !txSync_q[1];
         rxOut <= communicating_mode ? !rxSync_q[1] : 1'b1;
      end
   end

   // =========================================
   // Wake flag and reporting
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus_wake_flag <= 1'b0;
         commSeen_q    <= 1'b0;
      end else begin
         if (!communicating_mode)
            commSeen_q <= 1'b0;
         else if (canRegRead)
            commSeen_q <= 1'b1;
         if (wakeHit && chipMode != CHIP_SLEEP)
            bus_wake_flag <= 1'b1;
         else if (commSeen_q && communicating_mode)
            bus_wake_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         deepWake_q <= 1'b0;
      else if (chipMode != CHIP_SLEEP || communicating_mode)
         deepWake_q <= 1'b0;
      else if (wakeHit)
         deepWake_q <= 1'b1;
   end

   assign deepOff = (chipMode == CHIP_SLEEP) && !deepWake_q && !wakeHit;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         regulatorOn      <= 1'b1;
         hostResetRelease <= 1'b1;
      end else begin
         regulatorOn      <= !deepOff;
         hostResetRelease <= !deepOff && regulatorOn;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         intCnt_q <= 3'h0;
      else if (wakeHit && chipMode == CHIP_STOP)
         intCnt_q <= 3'(INT_PULSE_CYC);
      else if (intCnt_q != 3'h0)
         intCnt_q <= intCnt_q - 3'h1;
   end
   assign intPulse = (intCnt_q != 3'h0);

   sleep_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !communicating_mode |=> !drvEnable && !drvDominant && !rxEnable)
      else $error("driver active in sleep");
   recess_return_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(communicating_mode) |=> !drvDominant)
      else $error("not recessive on return");
   wake_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      wakeInternal && !commCmd |=> wakeInternal)
      else $error("wake dropped early");
   stop_int_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      wakeHit && chipMode == CHIP_STOP |=> intPulse && bus_wake_flag)
      else $error("stop wake not reported");
   flag_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      bus_wake_flag && !communicating_mode |=> bus_wake_flag)
      else $error("flag cleared outside comm");
   reg_order_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      hostResetRelease |-> regulatorOn)
      else $error("reset released before regulator");
   tx_pol_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      communicating_mode && drvEnable && txSync_q[1] |=> !drvDominant)
      else $error("high transmit drove dominant");
   rx_pol_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      communicating_mode && rxSync_q[1] |=> !rxOut)
      else $error("dominant bus read high");
   slew_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !commCmd |=> $stable(slewRate_q))
      else $error("edge rate changed unasked");
   slew_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      commCmd |=> slewRate_q == $past(slewSel))
      else $error("edge rate not loaded");
   wake_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == XCVR_SLEEP && !wakeEn_q |=> !wakeHit)
      else $error("wake while disabled");
   supply_sleep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      communicating_mode && sleepCmd && transceiver_supply |=> !communicating_mode)
      else $error("sleep refused with supply");
   wake_enter_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == XCVR_SLEEP && wakeHit && !commCmd |=> wakeInternal)
      else $error("wake state not entered");
   deep_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      chipMode == CHIP_SLEEP && !deepWake_q && !wakeHit |=> !regulatorOn && !hostResetRelease)
      else $error("regulator on in deep sleep");
   deep_wake_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      wakeHit && chipMode == CHIP_SLEEP |=> regulatorOn ##1 hostResetRelease)
      else $error("deep wake not reported");
   flag_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      wakeHit && chipMode inside {CHIP_NORMAL, CHIP_STANDBY} |=> bus_wake_flag && !intPulse)
      else $error("wake not flagged alone");
   tx_dom_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      communicating_mode && drvEnable && !txSync_q[1] |=> drvDominant)
      else $error("low transmit not dominant");
   rx_rec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      communicating_mode && !rxSync_q[1] |=> rxOut)
      else $error("recessive bus read low");
endmodule

// *** can_bus_node.sv ***
`timescale 1ns/1ps
module can_bus_node (
   input  wire logic ref_clk,
   input  wire logic drvEnable,
   input  wire logic drvDominant,
   output logic      busDiff,
   output logic      wakeRx
);
   logic nodeDom;

   initial nodeDom = 1'b0;

   // ====================
   // Bus level
   // drive bus
   assign busDiff = nodeDom | (drvEnable & drvDominant);
   assign wakeRx  = busDiff;

   // ====================
   // Pulses
   task automatic pulse(input int w, input int g);
      @(negedge ref_clk);
      nodeDom = 1'b1;
      repeat (w) @(negedge ref_clk);
      nodeDom = 1'b0;
      repeat (g - 1) @(negedge ref_clk);
   endtask
endmodule

// *** can_transceiver_mode_wakeup_bench.sv ***
`timescale 1ns/1ps
module can_transceiver_mode_wakeup_bench;
   import can_wake_pkg::*;
   localparam int MINC = 2;
   localparam int MAXC = 40;
   localparam int GAPC = 40;
   localparam int WINC = 100;
   logic              ref_clk, nrst, txIn, busDiff, wakeRx, sleepCmd, commCmd;
   logic              wakeEnable, transceiver_supply, canRegRead;
   logic [SLEW_W-1:0] slewSel, slewRate_q;
   chip_mode_e        chipMode;
   logic              rxOut, drvDominant, drvEnable, rxEnable, communicating_mode;
   logic              bus_wake_flag, wakeInternal, regulatorOn, hostResetRelease, intPulse;
   logic [31:0]       seed;
   int                errCount, nCompared;
   int                cw [6][4] = '{'{1,5,5,5}, '{5,1,5,5}, '{5,5,60,5},
                                    '{5,5,5,45}, '{30,30,30,30}, '{2,5,39,5}};

   can_transceiver_mode_wakeup #(.MIN_CYC(MINC), .MAX_CYC(MAXC), .GAP_CYC(GAPC),
      .WIN_CYC(WINC)) i_dut (.*);
   can_bus_node node (.ref_clk(ref_clk), .drvEnable(drvEnable),
      .drvDominant(drvDominant), .busDiff(busDiff), .wakeRx(wakeRx));

   // ====================
   // Clock and helpers
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   function automatic int pick(input int lo, input int span);
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return lo + int'(seed[15:0]) % span;
   endfunction

   function automatic logic wakeExp(input int a, b, c, g, input logic en);
      return en && a >= MINC && a < MAXC && b >= MINC && b < MAXC && c >= MINC
         && c < MAXC && g < GAPC && (2 * g + b + c) < WINC;
   endfunction

   task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stopTest();
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ====================
   // Mode tasks
   task automatic goComm(input logic [SLEW_W-1:0] s);
      @(negedge ref_clk);
      slewSel = s;
      commCmd = 1'b1;
      @(negedge ref_clk);
      commCmd = 1'b0;
      repeat (3) @(negedge ref_clk);
      check("comm", communicating_mode, 1'b1);
      check("slew", slewRate_q, s);
      check("drvEn", drvEnable, 1'b1);
      check("drvDom", drvDominant, 1'b0);
      check("wakeInt", wakeInternal, 1'b0);
      txIn = 1'b0;
      repeat (6) @(negedge ref_clk);
      check("drvDom", drvDominant, 1'b1);
      check("rxOut", rxOut, 1'b0);
      txIn = 1'b1;
      repeat (6) @(negedge ref_clk);
      check("rxOut", rxOut, 1'b1);
      canRegRead = 1'b1;
      @(negedge ref_clk);
      canRegRead = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("flag", bus_wake_flag, 1'b0);
   endtask

   task automatic goSleep(input logic en);
      @(negedge ref_clk);
      wakeEnable = en;
      transceiver_supply = seed[3];
      sleepCmd = 1'b1;
      @(negedge ref_clk);
      sleepCmd = 1'b0;
      repeat (3) @(negedge ref_clk);
      check("comm", communicating_mode, 1'b0);
      check("drvEn", drvEnable, 1'b0);
      check("rxEn", rxEnable, 1'b0);
      repeat (50) @(negedge ref_clk);
   endtask

   task automatic pattern(input int a, b, c, g, input logic en);
      logic exp, intSeen;
      exp = wakeExp(a, b, c, g, en);
      intSeen = 1'b0;
      node.pulse(a, g);
      node.pulse(b, g);
      node.pulse(c, 1);
      for (int i = 0; i < 12; i++) begin
         @(negedge ref_clk);
         intSeen = intSeen | intPulse;
      end
      check("wakeInt", wakeInternal, exp);
      check("flag", bus_wake_flag, exp && chipMode != CHIP_SLEEP);
      check("int", intSeen, exp && chipMode == CHIP_STOP);
      check("reg", regulatorOn, exp || chipMode != CHIP_SLEEP);
      check("rstRel", hostResetRelease, exp || chipMode != CHIP_SLEEP);
   endtask

   // ====================
   // Main sequence
   initial begin
      {nrst, sleepCmd, commCmd, wakeEnable, canRegRead, slewSel} = '0;
      {txIn, transceiver_supply} = 2'b11;
      chipMode = CHIP_NORMAL;
      seed = 32'hb222facb;
      errCount = 0;
      nCompared = 0;
      repeat (20) @(negedge ref_clk);
      nrst = 1'b1;
      check("rxOut", rxOut, 1'b1);
      check("drvEn", drvEnable, 1'b0);
      check("flag", bus_wake_flag, 1'b0);
      for (int s = 0; s < 4; s++) begin
         goComm(s[SLEW_W-1:0]);
         goSleep(1'b1);
      end
      pattern(5, 5, 5, 5, 1'b1);
      canRegRead = 1'b1;
      @(negedge ref_clk);
      canRegRead = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("flag", bus_wake_flag, 1'b1);
      goComm(2'h1);
      $display("test flag done");
      for (int i = 0; i < 20; i++) begin
         chipMode = chip_mode_e'(2'(pick(0, 4)));
         goSleep(i < 6 || seed[4]);
         if (i < 6)
            pattern(cw[i][0], cw[i][1], cw[i][2], cw[i][3], 1'b1);
         else
            pattern(pick(1, 44), pick(1, 44), pick(1, 44), pick(2, 24), wakeEnable);
         goComm(2'(pick(0, 4)));
         $display("test %0d done", i);
      end
      stopTest();
   end

   initial begin
      #(40 * 100000);
      errCount++;
      stopTest();
   end
endmodule
